// [common/rvw_map.vh]
// Address map, field layout and reset values of the regulator window bank
`ifndef RVW_MAP_VH
`define RVW_MAP_VH

`define RVW_ADDR_W 8
`define RVW_DATA_W 8
`define RVW_IDX_W 4

// Register offsets
`define RVW_ADDR_REG1_CODE_A 8'h0e
`define RVW_ADDR_REG1_CODE_B 8'h0f
`define RVW_ADDR_REG2_CODE_A 8'h10
`define RVW_ADDR_REG2_CODE_B 8'h11
`define RVW_ADDR_REG3_CODE_A 8'h12
`define RVW_ADDR_REG3_CODE_B 8'h13
`define RVW_ADDR_REG4_CODE_A 8'h14
`define RVW_ADDR_REG4_CODE_B 8'h15
`define RVW_ADDR_REG1_WINDOW 8'h18
`define RVW_ADDR_REG2_WINDOW 8'h19
`define RVW_ADDR_REG3_WINDOW 8'h1a
`define RVW_ADDR_REG4_WINDOW 8'h1b
`define RVW_ADDR_SELECT 8'h1c
`define RVW_ADDR_LOAD_STATUS 8'h1d

// Storage indices
`define RVW_IDX_FIRST_CODE 4'h0
`define RVW_IDX_FIRST_WINDOW 4'h8
`define RVW_IDX_SELECT 4'hc
`define RVW_IDX_NONE 4'hf
`define RVW_NUM_REGS 13
`define RVW_LAST_IDX 4'hc

// Field layout
`define RVW_LOW_MSB 5
`define RVW_LOW_LSB 3
`define RVW_HIGH_MSB 2
`define RVW_HIGH_LSB 0
`define RVW_THR_W 3
`define RVW_NUM_REGULATORS 4

// Values
`define RVW_RESET_BYTE 8'h00
`define RVW_FULL_MASK 8'hff
`define RVW_SELECT_MASK 8'h0f
`define RVW_STATUS_BUSY_BIT 0
`define RVW_STATUS_LOADED_BIT 1

`endif

// [hdl/rvw_default_mem.v]
// Small memory holding the nonvolatile default image, registered read data
`timescale 1ns/1ps
module rvw_default_mem #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire ref_clk_in,
  input wire arst_n_in,
  input wire wr_en_in,
  input wire [AW-1:0] wr_addr_in,
  input wire [WIDTH-1:0] wr_data_in,
  input wire rd_en_in,
  input wire [AW-1:0] rd_addr_in,
  output wire [WIDTH-1:0] rd_data_out
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [WIDTH-1:0] rd_data_q;

  // Image store, no reset on the array
  always @(posedge ref_clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  // Read register
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_data_q <= {WIDTH{1'b0}};
    end else if (rd_en_in) begin
      rd_data_q <= mem_q[rd_addr_in];
    end
  end

  assign rd_data_out = rd_data_q;

endmodule

// [hdl/rvw_regs.v]
// Voltage code and power-good window register bank for four regulators
//
// Operation
// [R1] Each regulator has two 8-bit read/write voltage code registers, whole byte one field.
// [R2] Every code and threshold field is overwritten by the nonvolatile defaults when loaded.
// [R3] A per-regulator select bit picks the first code register on zero, the second on one.
// [R4] Window bits 5 to 3 hold the low threshold code, -3% up to -10%.
// [R5] Window bits 2 to 0 hold the high threshold code, +3% up to +10%.
// [R6] The four window registers sit at 0x18 to 0x1b in regulator order and reset to 0x00.
// [R7] Code pairs of regulators two to four sit at 0x10/0x11, 0x12/0x13, 0x14/0x15, reset 0x00.
// [R8] Reserved window bits 7 and 6 are stored and read back with no effect on thresholds.
`timescale 1ns/1ps
`include "rvw_map.vh"
module rvw_regs #(
  parameter NUM_REGS = `RVW_NUM_REGS,
  parameter MEM_DEPTH = 16
) (
  input wire ref_clk_in,
  input wire arst_n_in,
  input wire [`RVW_ADDR_W-1:0] addr_in,
  input wire [`RVW_DATA_W-1:0] wr_data_in,
  input wire wr_en_in,
  input wire rd_en_in,
  output wire [`RVW_DATA_W-1:0] rd_data_out,
  input wire nv_wr_en_in,
  input wire [`RVW_IDX_W-1:0] nv_wr_addr_in,
  input wire [`RVW_DATA_W-1:0] nv_wr_data_in,
  input wire nv_load_in,
  output wire nv_busy_out,
  output wire nv_done_out,
  output wire [4*`RVW_DATA_W-1:0] active_code_out,
  output wire [4*`RVW_THR_W-1:0] low_threshold_out,
  output wire [4*`RVW_THR_W-1:0] high_threshold_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding

  function [`RVW_IDX_W-1:0] addr_to_idx;
    input [`RVW_ADDR_W-1:0] a;
    begin
      case (a)
        `RVW_ADDR_REG1_CODE_A: addr_to_idx = 4'h0;
        `RVW_ADDR_REG1_CODE_B: addr_to_idx = 4'h1;
        `RVW_ADDR_REG2_CODE_A: addr_to_idx = 4'h2; // see [R7]
        `RVW_ADDR_REG2_CODE_B: addr_to_idx = 4'h3; // see [R7]
        `RVW_ADDR_REG3_CODE_A: addr_to_idx = 4'h4; // see [R7]
        `RVW_ADDR_REG3_CODE_B: addr_to_idx = 4'h5; // see [R7]
        `RVW_ADDR_REG4_CODE_A: addr_to_idx = 4'h6; // see [R7]
        `RVW_ADDR_REG4_CODE_B: addr_to_idx = 4'h7; // see [R7]
        `RVW_ADDR_REG1_WINDOW: addr_to_idx = 4'h8; // see [R6]
        `RVW_ADDR_REG2_WINDOW: addr_to_idx = 4'h9; // see [R6]
        `RVW_ADDR_REG3_WINDOW: addr_to_idx = 4'ha; // see [R6]
        `RVW_ADDR_REG4_WINDOW: addr_to_idx = 4'hb; // see [R6]
        `RVW_ADDR_SELECT: addr_to_idx = `RVW_IDX_SELECT;
        default: addr_to_idx = `RVW_IDX_NONE;
      endcase
    end
  endfunction

  // Select register keeps only its regulator bits
  function [`RVW_DATA_W-1:0] idx_mask;
    input [`RVW_IDX_W-1:0] i;
    begin
      if (i == `RVW_IDX_SELECT) begin
        idx_mask = `RVW_SELECT_MASK;
      end else begin
        idx_mask = `RVW_FULL_MASK; // see [R1] [R8]
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Default loader state machine

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_FINISH = 3'b100;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [`RVW_IDX_W-1:0] ptr_q;
  reg [`RVW_IDX_W-1:0] ptr_d;
  reg ld_valid_q;
  reg [`RVW_IDX_W-1:0] ld_idx_q;
  reg busy_q;
  reg done_q;
  reg loaded_q;
  reg mem_rd_en;
  wire [`RVW_DATA_W-1:0] mem_rd_data;

  always @* begin
    state_d = state_q;
    ptr_d = ptr_q;
    mem_rd_en = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (nv_load_in) begin
          state_d = ST_RUN;
          ptr_d = `RVW_IDX_FIRST_CODE;
        end
      end
      ST_RUN: begin
        mem_rd_en = 1'b1;
        if (ptr_q == `RVW_LAST_IDX) begin
          state_d = ST_FINISH;
        end else begin
          ptr_d = ptr_q + 4'h1;
        end
      end
      ST_FINISH: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= ST_IDLE;
      ptr_q <= `RVW_IDX_FIRST_CODE;
      ld_valid_q <= 1'b0;
      ld_idx_q <= `RVW_IDX_FIRST_CODE;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      loaded_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ptr_q <= ptr_d;
      ld_valid_q <= mem_rd_en;
      ld_idx_q <= ptr_q;
      busy_q <= (state_d != ST_IDLE);
      done_q <= (state_q == ST_FINISH);
      if (state_q == ST_FINISH) begin
        loaded_q <= 1'b1;
      end
    end
  end

  rvw_default_mem #(
    .WIDTH(`RVW_DATA_W),
    .DEPTH(MEM_DEPTH),
    .AW(`RVW_IDX_W)
  ) u_defaults (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .wr_en_in(nv_wr_en_in),
    .wr_addr_in(nv_wr_addr_in),
    .wr_data_in(nv_wr_data_in),
    .rd_en_in(mem_rd_en),
    .rd_addr_in(ptr_q),
    .rd_data_out(mem_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  reg [`RVW_DATA_W-1:0] regs_q [0:NUM_REGS-1];
  wire [`RVW_IDX_W-1:0] bus_idx;
  integer i;

  assign bus_idx = addr_to_idx(addr_in);

  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (i = 0; i < NUM_REGS; i = i + 1) begin
        regs_q[i] <= `RVW_RESET_BYTE; // see [R6] [R7]
      end
    end else begin
      for (i = 0; i < NUM_REGS; i = i + 1) begin
        if (ld_valid_q && (ld_idx_q == i[`RVW_IDX_W-1:0])) begin
          // Defaults win over a bus write in the same cycle
          regs_q[i] <= mem_rd_data & idx_mask(ld_idx_q); // see [R2]
        end else if (wr_en_in && (bus_idx == i[`RVW_IDX_W-1:0])) begin
          regs_q[i] <= wr_data_in & idx_mask(bus_idx); // see [R1] [R8]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  reg [`RVW_DATA_W-1:0] rd_data_q;
  reg [`RVW_DATA_W-1:0] rd_mux;

  always @* begin
    rd_mux = `RVW_RESET_BYTE;
    if (addr_in == `RVW_ADDR_LOAD_STATUS) begin
      rd_mux[`RVW_STATUS_BUSY_BIT] = busy_q;
      rd_mux[`RVW_STATUS_LOADED_BIT] = loaded_q;
    end else if (bus_idx != `RVW_IDX_NONE) begin
      rd_mux = regs_q[bus_idx]; // see [R8]
    end
  end

  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_data_q <= `RVW_RESET_BYTE;
    end else if (rd_en_in) begin
      rd_data_q <= rd_mux;
    end else begin
      rd_data_q <= `RVW_RESET_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-regulator outputs

  reg [4*`RVW_DATA_W-1:0] code_q;
  reg [4*`RVW_THR_W-1:0] low_q;
  reg [4*`RVW_THR_W-1:0] high_q;
  wire [`RVW_DATA_W-1:0] select_reg;

  assign select_reg = regs_q[`RVW_IDX_SELECT];

  genvar g;
  generate
    for (g = 0; g < `RVW_NUM_REGULATORS; g = g + 1) begin : g_reg
      wire [`RVW_DATA_W-1:0] code_first;
      wire [`RVW_DATA_W-1:0] code_second;
      wire [`RVW_DATA_W-1:0] window;
      assign code_first = regs_q[2*g];
      assign code_second = regs_q[2*g+1];
      assign window = regs_q[`RVW_IDX_FIRST_WINDOW+g];
      always @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          code_q[g*`RVW_DATA_W +: `RVW_DATA_W] <= `RVW_RESET_BYTE;
          low_q[g*`RVW_THR_W +: `RVW_THR_W] <= {`RVW_THR_W{1'b0}};
          high_q[g*`RVW_THR_W +: `RVW_THR_W] <= {`RVW_THR_W{1'b0}};
        end else begin
          if (select_reg[g]) begin
            code_q[g*`RVW_DATA_W +: `RVW_DATA_W] <= code_second; // see [R3]
          end else begin
            code_q[g*`RVW_DATA_W +: `RVW_DATA_W] <= code_first; // see [R3]
          end
          low_q[g*`RVW_THR_W +: `RVW_THR_W] <= window[`RVW_LOW_MSB:`RVW_LOW_LSB]; // see [R4]
          high_q[g*`RVW_THR_W +: `RVW_THR_W] <= window[`RVW_HIGH_MSB:`RVW_HIGH_LSB]; // see [R5]
        end
      end
    end
  endgenerate

  assign rd_data_out = rd_data_q;
  assign nv_busy_out = busy_q;
  assign nv_done_out = done_q;
  assign active_code_out = code_q;
  assign low_threshold_out = low_q;
  assign high_threshold_out = high_q;

endmodule

// [sim/rvw_regs_asserts.sv]
// Port assertions for the regulator window register bank
`timescale 1ns/1ps
module rvw_regs_chk (
  input wire ref_clk_in,
  input wire arst_n_in,
  input wire [7:0] addr_in,
  input wire [7:0] wr_data_in,
  input wire wr_en_in,
  input wire rd_en_in,
  input wire [7:0] rd_data_out,
  input wire nv_load_in,
  input wire nv_busy_out,
  input wire nv_done_out,
  input wire [11:0] low_threshold_out,
  input wire [11:0] high_threshold_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  property p_rd_idle;
    !rd_en_in |=> rd_data_out == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_low1;
    wr_en_in && addr_in == 8'h18 && !nv_busy_out |=> ##1
      low_threshold_out[2:0] == $past(wr_data_in[5:3], 2);
  endproperty
  a_low1: assert property (p_low1) else $error("low threshold wrong");
  property p_high4;
    wr_en_in && addr_in == 8'h1b && !nv_busy_out |=> ##1
      high_threshold_out[11:9] == $past(wr_data_in[2:0], 2);
  endproperty
  a_high4: assert property (p_high4) else $error("high threshold wrong");
  property p_rsv_back;
    wr_en_in && addr_in == 8'h1a && !nv_busy_out ##1 rd_en_in && addr_in == 8'h1a
      |=> rd_data_out == $past(wr_data_in, 2);
  endproperty
  a_rsv_back: assert property (p_rsv_back) else $error("window readback wrong");
  property p_code_back;
    wr_en_in && addr_in == 8'h15 && !nv_busy_out ##1 rd_en_in && addr_in == 8'h15
      |=> rd_data_out == $past(wr_data_in, 2);
  endproperty
  a_code_back: assert property (p_code_back) else $error("code readback wrong");
  property p_load;
    nv_load_in && !nv_busy_out |=> nv_busy_out [*7] ##1 nv_busy_out [*7] ##1
      (nv_done_out && !nv_busy_out);
  endproperty
  a_load: assert property (p_load) else $error("load timing wrong");
  property p_done_one;
    nv_done_out |=> !nv_done_out;
  endproperty
  a_done_one: assert property (p_done_one) else $error("done too long");
  property p_done_after;
    nv_done_out |-> $past(nv_busy_out) && !nv_busy_out;
  endproperty
  a_done_after: assert property (p_done_after) else $error("done without load");
endmodule
bind rvw_regs rvw_regs_chk u_chk (.ref_clk_in, .arst_n_in, .addr_in, .wr_data_in, .wr_en_in,
  .rd_en_in, .rd_data_out, .nv_load_in, .nv_busy_out, .nv_done_out, .low_threshold_out,
  .high_threshold_out);

// [sim/test_regulator_voltage_window_regs.sv]
// Self-checking bench for the regulator window register bank
`timescale 1ns/1ps
module test_regulator_voltage_window_regs;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00, wd = 8'h00, nwd = 8'h00, rd, pexp, st;
  logic we = 1'b0, re = 1'b0, nwe = 1'b0, nld = 1'b0, pend = 1'b0, busy, done;
  logic [3:0] nwa = 4'h0;
  logic [31:0] act;
  logic [11:0] lo, hi;
  logic [7:0] m [0:255];
  logic [7:0] img [0:12];
  int fails = 0, checks = 0, cyc = 0, k;
  always #25 clk = ~clk;
  rvw_regs u_dut (.ref_clk_in(clk), .arst_n_in(rst_n), .addr_in(addr), .wr_data_in(wd),
    .wr_en_in(we), .rd_en_in(re), .rd_data_out(rd), .nv_wr_en_in(nwe), .nv_wr_addr_in(nwa),
    .nv_wr_data_in(nwd), .nv_load_in(nld), .nv_busy_out(busy), .nv_done_out(done),
    .active_code_out(act), .low_threshold_out(lo), .high_threshold_out(hi));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a >= 8'h0e && a <= 8'h15) || (a >= 8'h18 && a <= 8'h1c);
  endfunction
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    exp_rd = a == 8'h1d ? st : (a == 8'h1c ? m[a] & 8'h0f : (mapped(a) ? m[a] : 8'h00));
  endfunction
  function automatic logic [31:0] e_act();
    for (int g = 0; g < 4; g++) e_act[8*g+:8] = m[14 + 2*g + m[8'h1c][g]];
  endfunction
  function automatic logic [11:0] e_thr(input int hs);
    for (int g = 0; g < 4; g++) e_thr[3*g+:3] = hs ? m[24+g][2:0] : m[24+g][5:3];
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic end_sim();
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    re <= 1'b0;
    @(posedge clk);
    if (mapped(a)) m[a] = d;
  endtask
  task automatic rdc(input logic [7:0] a);
    addr <= a;
    we <= 1'b0;
    re <= 1'b1;
    @(posedge clk);
  endtask
  task automatic idle();
    we <= 1'b0;
    re <= 1'b0;
    @(posedge clk);
  endtask
  task automatic outs();
    repeat (3) idle();
    chk("active_code", e_act(), act);
    chk("low_threshold", e_thr(0), lo);
    chk("high_threshold", e_thr(1), hi);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Read data checked one cycle after each strobe, zero otherwise
  always @(posedge clk) begin
    cyc++;
    if (rst_n) chk("rd_data", pend ? pexp : 8'h00, rd);
    pend <= re;
    pexp <= exp_rd(addr);
    if (cyc > 5000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(32'hcf1f));
    for (int i = 0; i < 256; i++) m[i] = 8'h00;
    st = 8'h00;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int a = 12; a < 32; a++) rdc(a[7:0]);
    outs();
    wr(8'h18, 8'hff);
    rdc(8'h18);
    wr(8'h1b, 8'hc7);
    rdc(8'h1b);
    wr(8'h1a, 8'hc5);
    rdc(8'h1a);
    wr(8'h15, 8'h3c);
    rdc(8'h15);
    outs();
    repeat (80) begin
      k = 14 + $urandom_range(0, 15);
      wr(k[7:0], 8'($urandom));
      if ($urandom_range(0, 1)) rdc(k[7:0]);
    end
    outs();
    for (int s = 0; s < 16; s++) begin
      wr(8'h1c, 8'(($urandom << 4) | s));
      rdc(8'h1c);
      outs();
    end
    // Default image written, then loaded with a stray start mid-load
    for (k = 0; k < 13; k++) begin
      img[k] = 8'($urandom);
      nwe <= 1'b1;
      nwa <= k[3:0];
      nwd <= img[k];
      @(posedge clk);
    end
    nwe <= 1'b0;
    nld <= 1'b1;
    @(posedge clk);
    nld <= 1'b0;
    for (k = 1; k < 40 && !done; k++) begin
      @(posedge clk);
      if (k == 4) chk("busy_mid", 1, busy);
      if (k == 4) nld <= 1'b1;
      if (k == 5) nld <= 1'b0;
    end
    chk("load_cycles", 16, k);
    chk("busy_end", 0, busy);
    for (int i = 0; i < 13; i++) m[i < 8 ? 14 + i : (i < 12 ? 16 + i : 28)] = img[i];
    st = 8'h02;
    for (int a = 14; a < 30; a++) rdc(a[7:0]);
    outs();
    end_sim();
  end
endmodule
